//--- cpag_map.svh
// register offsets, field positions and reset values of the circular pointer address generator
`ifndef CPAG_MAP_SVH
`define CPAG_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CPAG_OFF_AUX_PTR_BASE 8'h00
`define CPAG_OFF_COEFF_PTR 8'h20
`define CPAG_OFF_COEFF_PAGE 8'h24
`define CPAG_OFF_EXT_AUX_BASE 8'h40
`define CPAG_OFF_EXT_COEFF 8'h60
`define CPAG_OFF_SIZE_LOW 8'h80
`define CPAG_OFF_SIZE_HIGH 8'h84
`define CPAG_OFF_SIZE_COEFF 8'h88
`define CPAG_OFF_START_A 8'h90
`define CPAG_OFF_START_B 8'h94
`define CPAG_OFF_START_C 8'h98
`define CPAG_OFF_START_D 8'h9C
`define CPAG_OFF_START_COEFF 8'hA0
`define CPAG_OFF_STATUS_TWO 8'hB0

// ----------------------------------------------------------------
// fields and indices
// ----------------------------------------------------------------
`define CPAG_BIT_LEGACY 9
`define CPAG_COEFF_SEL 4'h8
`define CPAG_SIZE_LOW_IDX 2'h0
`define CPAG_SIZE_HIGH_IDX 2'h1
`define CPAG_SIZE_COEFF_IDX 2'h2
`define CPAG_START_COEFF_IDX 3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CPAG_RST_WORD 16'h0000
`define CPAG_RST_PAGE 7'h00
`define CPAG_RST_CIRC 9'h000

`endif

//--- cpag_pkg.sv
// types shared by the circular pointer address generator
package cpag_pkg;

  // ----------------------------------------------------------------
  // pointer modification kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPAG_OP_POST = 3'b001,
    CPAG_OP_PRE = 3'b010,
    CPAG_OP_OFFSET = 3'b100
  } cpag_op_t;

  typedef enum logic [1:0] {
    CPAG_APB_IDLE = 2'b01,
    CPAG_APB_ANSWER = 2'b10
  } cpag_apb_state_t;

  // ----------------------------------------------------------------
  // address generation request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [3:0] ptrSel;
    cpag_op_t op;
    logic [15:0] step;
    logic circQualifier;
    logic bitMode;
  } cpag_gen_req_t;

  typedef struct packed {
    logic valid;
    logic [22:0] addr;
    logic circular;
  } cpag_gen_rsp_t;

  // ----------------------------------------------------------------
  // whole state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0][15:0] ptr;
    logic [8:0][6:0] page;
    logic [2:0][15:0] size;
    logic [4:0][15:0] start;
    logic [8:0] circSel;
    logic legacyCompatMode;
    cpag_apb_state_t apbState;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cpag_gen_rsp_t rsp;
  } cpag_state_t;

endpackage

//--- cpag_window_mask.sv
// window mask of the smallest power of two above the buffer length
`timescale 1ns/1ps
module cpag_window_mask #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] bufLength,
  output logic [WIDTH-1:0] windowMask
);

  // ----------------------------------------------------------------
  // bit i is in the window when any length bit at or above i is set
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_smear
      assign windowMask[i] = |bufLength[WIDTH-1:i];
    end
  endgenerate

endmodule

//--- cpag_circ_modify.sv
// linear or circular modification of one 16-bit pointer
`timescale 1ns/1ps
module cpag_circ_modify #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] ptrIn,
  input wire logic [WIDTH-1:0] step,
  input wire logic [WIDTH-1:0] bufLength,
  input wire logic [WIDTH-1:0] windowMask,
  input wire logic circular,
  output logic [WIDTH-1:0] ptrOut
);

  logic [WIDTH-1:0] linearSum;
  logic [WIDTH-1:0] lowPtr;
  logic [WIDTH-1:0] lowSum;
  logic [WIDTH-1:0] stepMag;
  logic [WIDTH-1:0] lowWrapped;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // wraps modulo 64K
  assign linearSum = ptrIn + step;
  assign lowPtr = ptrIn & windowMask;
  assign lowSum = lowPtr + step;
  assign stepMag = (~step) + {{(WIDTH-1){1'b0}}, 1'b1};

  always_comb begin
    if (!step[WIDTH-1]) begin
      // past the end restarts at top
      lowWrapped = (lowSum >= bufLength) ? lowSum - bufLength : lowSum;
    end else begin
      // below the top wraps to end
      lowWrapped = (lowPtr < stepMag) ? lowPtr + bufLength - stepMag : lowPtr - stepMag;
    end
  end

  assign ptrOut = (circular && (bufLength != '0)) ?
                  ((ptrIn & ~windowMask) | (lowWrapped & windowMask)) : linearSum;

endmodule

//--- cpag_top.sv
// circular pointer address generator with its APB register file
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cpag_map.svh"

module cpag_top
  import cpag_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire cpag_gen_req_t genReq,
  output cpag_gen_rsp_t genRsp
);

  cpag_state_t state_reg;
  cpag_state_t state_next;

  logic [15:0] selSize;
  logic [15:0] selStart;
  logic [15:0] selPtr;
  logic [6:0] selPage;
  logic selCircular;
  logic [15:0] winMask;
  logic [15:0] modPtr;
  logic [15:0] addrIndex;
  logic [22:0] genAddr;
  logic [22:0] pageBase;
  logic [22:0] startExt;
  logic reqLegal;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] sizeIndex(input logic [3:0] sel, input logic legacy);
    if (sel == `CPAG_COEFF_SEL) begin
      return `CPAG_SIZE_COEFF_IDX;
    end else if (!sel[2] || legacy) begin
      return `CPAG_SIZE_LOW_IDX;
    end else begin
      return `CPAG_SIZE_HIGH_IDX;
    end
  endfunction

  function automatic logic [2:0] startIndex(input logic [3:0] sel);
    if (sel == `CPAG_COEFF_SEL) begin
      return `CPAG_START_COEFF_IDX;
    end else begin
      return {1'b0, sel[2:1]};
    end
  endfunction

  function automatic logic ptrKnown(input logic [3:0] sel);
    return sel <= `CPAG_COEFF_SEL;
  endfunction

  // ----------------------------------------------------------------
  // register map decode
  // ----------------------------------------------------------------
  function automatic logic isAuxWord(input logic [7:0] a);
    return a < `CPAG_OFF_COEFF_PTR;
  endfunction

  function automatic logic isExtAuxWord(input logic [7:0] a);
    return (a >= `CPAG_OFF_EXT_AUX_BASE) && (a < `CPAG_OFF_EXT_COEFF);
  endfunction

  function automatic logic [31:0] lowWord(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  function automatic logic [31:0] extWord(input logic [6:0] pg, input logic [15:0] p);
    return {9'h000, pg, p};
  endfunction

  // misaligned and unlisted offsets answer with an error
  function automatic logic isMapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] == 2'b00) begin
      if (isAuxWord(a) || isExtAuxWord(a)) begin
        hit = 1'b1;
      end
      if (a == `CPAG_OFF_COEFF_PTR || a == `CPAG_OFF_COEFF_PAGE || a == `CPAG_OFF_EXT_COEFF) begin
        hit = 1'b1;
      end
      if (a >= `CPAG_OFF_SIZE_LOW && a <= `CPAG_OFF_SIZE_COEFF) begin
        hit = 1'b1;
      end
      if (a >= `CPAG_OFF_START_A && a <= `CPAG_OFF_START_COEFF) begin
        hit = 1'b1;
      end
      if (a == `CPAG_OFF_STATUS_TWO) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      // a lane with its strobe low keeps the stored byte
      if (strb[b]) begin
        res[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] readWord(input cpag_state_t s, input logic [7:0] a);
    logic [31:0] d;
    // unused upper bits read as zero
    d = 32'h0000_0000;
    if (isAuxWord(a)) begin
      d = lowWord(s.ptr[a[4:2]]);
    end else if (isExtAuxWord(a)) begin
      d = extWord(s.page[a[4:2]], s.ptr[a[4:2]]);
    end else begin
      unique case (a)
        `CPAG_OFF_COEFF_PTR: d = lowWord(s.ptr[`CPAG_COEFF_SEL]);
        `CPAG_OFF_COEFF_PAGE: d = {25'h000_0000, s.page[`CPAG_COEFF_SEL]};
        `CPAG_OFF_EXT_COEFF: d = extWord(s.page[`CPAG_COEFF_SEL], s.ptr[`CPAG_COEFF_SEL]);
        `CPAG_OFF_SIZE_LOW: d = lowWord(s.size[`CPAG_SIZE_LOW_IDX]);
        `CPAG_OFF_SIZE_HIGH: d = lowWord(s.size[`CPAG_SIZE_HIGH_IDX]);
        `CPAG_OFF_SIZE_COEFF: d = lowWord(s.size[`CPAG_SIZE_COEFF_IDX]);
        `CPAG_OFF_START_A: d = lowWord(s.start[0]);
        `CPAG_OFF_START_B: d = lowWord(s.start[1]);
        `CPAG_OFF_START_C: d = lowWord(s.start[2]);
        `CPAG_OFF_START_D: d = lowWord(s.start[3]);
        `CPAG_OFF_START_COEFF: d = lowWord(s.start[`CPAG_START_COEFF_IDX]);
        `CPAG_OFF_STATUS_TWO: d = {22'h00_0000, s.legacyCompatMode, s.circSel};
        default: d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // operand selection for the requested pointer
  // ----------------------------------------------------------------
  assign reqLegal = genReq.valid && ptrKnown(genReq.ptrSel);

  always_comb begin
    selSize = 16'h0000;
    selStart = 16'h0000;
    selPtr = 16'h0000;
    selPage = 7'h00;
    selCircular = 1'b0;
    // codes above the coefficient pointer select nothing
    if (ptrKnown(genReq.ptrSel)) begin
      // legacy forces the low group size on the aux pointers; the coefficient pointer keeps its own size
      selSize = state_reg.size[sizeIndex(genReq.ptrSel, state_reg.legacyCompatMode)];
      selStart = state_reg.start[startIndex(genReq.ptrSel)];
      selPtr = state_reg.ptr[genReq.ptrSel];
      selPage = state_reg.page[genReq.ptrSel];
      selCircular = state_reg.circSel[genReq.ptrSel] | genReq.circQualifier;
    end
  end

  cpag_window_mask #(
    .WIDTH(16)
  ) u_window (
    .bufLength(selSize),
    .windowMask(winMask)
  );

  cpag_circ_modify #(
    .WIDTH(16)
  ) u_modify (
    .ptrIn(selPtr),
    .step(genReq.step),
    .bufLength(selSize),
    .windowMask(winMask),
    .circular(selCircular),
    .ptrOut(modPtr)
  );

  // ----------------------------------------------------------------
  // address forming
  // ----------------------------------------------------------------
  assign addrIndex = (genReq.op == CPAG_OP_POST) ? selPtr : modPtr;

  // start zero-extended to 23 bits
  // in circular word mode start plus index is summed on 23 bits, so it may carry into the page; circular bit mode sums on 16 bits
  assign startExt = {7'h00, selStart};
  assign pageBase = {selPage, 16'h0000};

  always_comb begin
    if (genReq.bitMode) begin
      genAddr = selCircular ? {7'h00, selStart + addrIndex} : {7'h00, addrIndex};
    end else if (selCircular) begin
      genAddr = pageBase + startExt + {7'h00, addrIndex};
    end else begin
      // page in the upper seven bits
      genAddr = {selPage, addrIndex};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wword;
    logic [2:0] auxIdx;
    state_next = state_reg;
    wword = 32'h0000_0000;
    auxIdx = paddr[4:2];

    // the answer is registered, so it shows one edge after the request
    state_next.rsp.valid = reqLegal;
    state_next.rsp.circular = reqLegal & selCircular;
    if (reqLegal) begin
      state_next.rsp.addr = genAddr;
      if (genReq.op != CPAG_OP_OFFSET) begin
        state_next.ptr[genReq.ptrSel] = modPtr;
      end
    end

    // one wait state: the answer is registered the cycle after the access edge
    unique case (state_reg.apbState)
      CPAG_APB_IDLE: begin
        if (psel && penable) begin
          state_next.apbState = CPAG_APB_ANSWER;
          state_next.pready = 1'b1;
          state_next.pslverr = !isMapped(paddr);
          state_next.prdata = pwrite ? 32'h0000_0000 : readWord(state_reg, paddr);
        end
      end
      CPAG_APB_ANSWER: begin
        state_next.apbState = CPAG_APB_IDLE;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        // applied after the generator update, so a same-edge bus write wins
        if (psel && penable && pwrite && isMapped(paddr)) begin
          wword = mergeLanes(readWord(state_reg, paddr), pwdata, pstrb);
          if (isAuxWord(paddr)) begin
            state_next.ptr[auxIdx] = wword[15:0];
          end else if (isExtAuxWord(paddr)) begin
            // aux page only through extended write
            state_next.ptr[auxIdx] = wword[15:0];
            state_next.page[auxIdx] = wword[22:16];
          end else begin
            unique case (paddr)
              `CPAG_OFF_COEFF_PTR: state_next.ptr[`CPAG_COEFF_SEL] = wword[15:0];
              `CPAG_OFF_COEFF_PAGE: state_next.page[`CPAG_COEFF_SEL] = wword[6:0];
              `CPAG_OFF_EXT_COEFF: begin
                state_next.ptr[`CPAG_COEFF_SEL] = wword[15:0];
                state_next.page[`CPAG_COEFF_SEL] = wword[22:16];
              end
              `CPAG_OFF_SIZE_LOW: state_next.size[`CPAG_SIZE_LOW_IDX] = wword[15:0];
              `CPAG_OFF_SIZE_HIGH: state_next.size[`CPAG_SIZE_HIGH_IDX] = wword[15:0];
              `CPAG_OFF_SIZE_COEFF: state_next.size[`CPAG_SIZE_COEFF_IDX] = wword[15:0];
              `CPAG_OFF_START_A: state_next.start[0] = wword[15:0];
              `CPAG_OFF_START_B: state_next.start[1] = wword[15:0];
              `CPAG_OFF_START_C: state_next.start[2] = wword[15:0];
              `CPAG_OFF_START_D: state_next.start[3] = wword[15:0];
              `CPAG_OFF_START_COEFF: state_next.start[`CPAG_START_COEFF_IDX] = wword[15:0];
              `CPAG_OFF_STATUS_TWO: begin
                state_next.circSel = wword[8:0];
                state_next.legacyCompatMode = wword[`CPAG_BIT_LEGACY];
              end
              default: state_next.circSel = state_next.circSel;
            endcase
          end
        end
      end
      default: begin
        state_next.apbState = CPAG_APB_IDLE;
        state_next.pready = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    // the idle state code is not all zeros, so the fields are reset one by one
    if (!reset_n) begin
      for (int p = 0; p < 9; p++) begin
        state_reg.ptr[p] <= `CPAG_RST_WORD;
        state_reg.page[p] <= `CPAG_RST_PAGE;
      end
      for (int k = 0; k < 3; k++) begin
        state_reg.size[k] <= `CPAG_RST_WORD;
      end
      for (int k = 0; k < 5; k++) begin
        state_reg.start[k] <= `CPAG_RST_WORD;
      end
      state_reg.circSel <= `CPAG_RST_CIRC;
      state_reg.legacyCompatMode <= 1'b0;
      state_reg.apbState <= CPAG_APB_IDLE;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.rsp <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign prdata = state_reg.prdata;
  assign genRsp = state_reg.rsp;

endmodule

//--- cpag_monitor.sv
// concurrent checks on the ports of the circular pointer address generator
`timescale 1ns/1ps
module cpag_monitor
  import cpag_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire cpag_gen_req_t genReq,
  input wire cpag_gen_rsp_t genRsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer late or long");
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_prdata_hold;
    !pready |-> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");

  // ----------------------------------------------------------------
  // generator answer
  // ----------------------------------------------------------------
  property p_rsp_follows;
    genReq.valid && genReq.ptrSel <= 4'h8 |=> genRsp.valid;
  endproperty
  a_rsp_follows: assert property (p_rsp_follows) else $error("no address answer");
  property p_refuse;
    !(genReq.valid && genReq.ptrSel <= 4'h8) |=> !genRsp.valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("answer without request");
  property p_bit_page;
    genReq.valid && genReq.bitMode && genReq.ptrSel <= 4'h8 |=> genRsp.addr[22:16] == 7'h00;
  endproperty
  a_bit_page: assert property (p_bit_page) else $error("page in bit address");
  property p_qual;
    genReq.valid && genReq.circQualifier && genReq.ptrSel <= 4'h8 |=> genRsp.circular;
  endproperty
  a_qual: assert property (p_qual) else $error("qualifier ignored");
endmodule

//--- circular_pointer_address_gen_test.sv
// self-checking bench of the circular pointer address generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module circular_pointer_address_gen_test
  import cpag_pkg::*;
;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdq;
  logic [3:0] pstrb = 4'hF;
  logic rerr;
  cpag_gen_req_t genReq = '0;
  cpag_gen_rsp_t genRsp;
  int fails = 0, totalChecks = 0;

  cpag_top uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .genReq(genReq), .genRsp(genRsp));

  always #2.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdq = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read data", ex, rdq)
  endtask

  task automatic gen(input logic [3:0] s, input cpag_op_t o, input logic [15:0] st,
                     input logic q, input logic b, input logic ev, input logic [22:0] ea);
    @(posedge core_clk);
    genReq <= '{1'b1, s, o, st, q, b};
    @(posedge core_clk);
    genReq.valid <= 1'b0;
    @(posedge core_clk);
    `CHK("answer valid", ev, genRsp.valid)
    if (ev) `CHK("address", ea, genRsp.addr)
  endtask

  task automatic endTest(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fails);
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    printVerdict();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1;
    rd(8'hB0, 32'h0000_0000); // circular selects clear
    rd(8'h80, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, rerr)
    endTest("reset");
    wr(8'h80, 32'h0000_0003);
    wr(8'hB0, 32'h0000_0002);
    wr(8'h44, 32'h0001_0000);
    wr(8'h90, 32'h0000_0A02);
    wr(8'h04, 32'h0000_0000); // index below length
    gen(4'h1, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h01_0A02); // start plus page
    gen(4'h1, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h01_0A03); // step below length
    gen(4'h1, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h01_0A04);
    gen(4'h1, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h01_0A02); // wrap past end
    rd(8'h44, 32'h0001_0001); // page kept
    gen(4'h1, CPAG_OP_POST, 16'hFFFF, 0, 0, 1, 23'h01_0A03); // step never 8000h
    gen(4'h1, CPAG_OP_POST, 16'hFFFF, 0, 0, 1, 23'h01_0A02);
    rd(8'h04, 32'h0000_0002); // wrap below top
    endTest("word buffer");
    wr(8'hB0, 32'h0000_0220);
    wr(8'h54, 32'h0000_0002);
    pstrb <= 4'h1;
    wr(8'h84, 32'h0000_FF02);
    pstrb <= 4'hF;
    rd(8'h84, 32'h0000_0002); // high size, low lane only
    gen(4'h5, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h00_0002); // low size used
    gen(4'h5, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h00_0000); // wrapped by low size
    wr(8'hB0, 32'h0000_0020);
    gen(4'h5, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h00_0001); // high size governs
    gen(4'h5, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h00_0000); // wrapped by high size
    endTest("legacy mode");
    wr(8'hB0, 32'h0000_0000);
    wr(8'h94, 32'h0000_0010);
    wr(8'h0C, 32'h0000_0002);
    gen(4'h3, CPAG_OP_POST, 16'h0001, 1, 0, 1, 23'h00_0012); // qualifier forces circular
    gen(4'h3, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h00_0000); // pair start ignored when linear
    rd(8'h0C, 32'h0000_0001); // linear when select clear
    endTest("qualifier");
    wr(8'h24, 32'h0000_0005);
    wr(8'h88, 32'h0000_0008);
    wr(8'hA0, 32'h0000_0100);
    wr(8'hB0, 32'h0000_0100);
    wr(8'h20, 32'h0000_0007);
    rd(8'h60, 32'h0005_0007); // coefficient page and pointer in one word
    gen(4'h8, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h05_0107); // page in upper bits
    rd(8'h20, 32'h0000_0000); // four-bit window for length 8
    gen(4'h8, CPAG_OP_OFFSET, 16'h0000, 0, 1, 1, 23'h00_0100); // bit buffer
    endTest("coefficient");
    wr(8'h40, 32'h0002_FFFF);
    gen(4'h0, CPAG_OP_POST, 16'h0001, 0, 0, 1, 23'h02_FFFF);
    rd(8'h40, 32'h0002_0000); // no carry into page
    gen(4'h0, CPAG_OP_PRE, 16'h0001, 0, 0, 1, 23'h02_0001);
    gen(4'h9, CPAG_OP_POST, 16'h0001, 0, 0, 0, 23'h00_0000);
    endTest("linear");
    printVerdict();
  end
endmodule

bind cpag_top cpag_monitor mon (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .genReq(genReq), .genRsp(genRsp));
